/* pkg/fold_cfg.svh */
// constants for the current loop foldback monitor
// included by the design, checker and testbench files; definitions only
`ifndef FOLD_CFG_SVH
`define FOLD_CFG_SVH
`define OFS_MEAS_CUR 12'h1b0
`define OFS_TOTAL_FF 12'h1b2
`define OFS_DRV_FOLD 12'h682
`define OFS_COMM_SEL 12'h6c2
`define OFS_MOTOR_KIND 12'h6c4
`define OFS_FOLD_FAULT 12'h6c6
`define OFS_LIMIT_P 12'h6c8
`define OFS_STATUS 12'h6ca
`define COMM_SEL_RESET 8'h00
`define COMM_SEL_SECONDARY 8'h01
`define MOTOR_KIND_SELECTABLE 8'h04
`define CUR_SCALE_INCR 32'd20130
`define FOLD_LIMIT_MAX 32'h7fffffff
`define FOLD_STEP_DIV 16'd1000
`define STAT_FAULT_BIT 0
`define STAT_FOLD_ACTIVE_BIT 1
`define STAT_SEL_SECONDARY_BIT 2
`endif

/* pkg/fold_pkg.sv */
// types for the current loop foldback monitor
// no dependencies
package fold_pkg;
   typedef enum logic [1:0] {st_run, st_fault} fold_state_t;
   typedef logic [31:0] reg_word_t;
endpackage

/* core/fold_step.sv */
// foldback integrator: moves the drive limit down or up once per step tick
// assumes currents in milliamps rms, unsigned magnitudes
`timescale 1ns/1ns
`include "fold_cfg.svh"
module fold_step #(
   parameter int W = 32
)(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic [W-1:0] actual_mag,
   input wire logic [W-1:0] continuous,
   input wire logic [W-1:0] ceiling,
   input wire logic [W-1:0] step,
   output logic [W-1:0] limit_q
);
   logic [W-1:0] limit_d;
   always_comb
   begin
      limit_d = limit_q;
      if (actual_mag > continuous)
         limit_d = (limit_q > step) ? limit_q - step : '0;
      else if (actual_mag < continuous)
         limit_d = (ceiling - limit_q > step) ? limit_q + step : ceiling;
      if (limit_d > W'(`FOLD_LIMIT_MAX))
         limit_d = W'(`FOLD_LIMIT_MAX);
   end
   // starts at max so a fresh drive is not folded back
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         limit_q <= W'(`FOLD_LIMIT_MAX);
      else if (tick)
         limit_q <= limit_d;
   end
endmodule

/* core/foldback_monitor.sv */
// register file plus foldback limiter; parameter port reg_* with one-cycle read data
// assumes same-clock samples from the current loop; currents in milliamps
`timescale 1ns/1ns
`include "fold_cfg.svh"
module foldback_monitor #(
   parameter int STEP_DIV = 1000,
   parameter int ADC_W = 16
)(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   input wire logic signed [ADC_W-1:0] cur_raw,
   input wire logic [31:0] hw_peak_ma,
   input wire logic [31:0] drive_cont_ma,
   input wire logic [31:0] fold_ceiling_ma,
   input wire logic [31:0] fold_step_ma,
   input wire logic signed [31:0] ff_sum,
   input wire logic [31:0] primary_angle,
   input wire logic [31:0] secondary_angle,
   output logic [31:0] active_limit_q,
   output logic [31:0] comm_angle_q,
   output logic fault_q,
   output logic drive_enable_q
);
   logic [7:0] comm_sel_q;
   logic [7:0] motor_kind_q;
   logic [31:0] fault_level_q;
   logic [31:0] limit_p_q;
   logic signed [31:0] meas_q;
   logic signed [31:0] ff_q;
   logic [15:0] div_q;
   logic tick_q;
   logic [31:0] drive_fold;
   logic [31:0] actual_mag;
   logic signed [63:0] meas_d;
   logic signed [31:0] meas_sat;
   logic [31:0] rdata_d;
   logic fold_active_q;
   logic sel_secondary_q;
   fold_pkg::fold_state_t state_q;

   // step tick divider keeps the integrator slow against the loop rate
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         div_q <= '0;
      else if (div_q == 16'(STEP_DIV - 1))
         div_q <= '0;
      else
         div_q <= div_q + 16'd1;
   end

   // one-cycle enable, never a clock of its own
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         tick_q <= 1'b0;
      else
         tick_q <= (div_q == 16'(STEP_DIV - 1));
   end

   // scale raw counts by hardware peak over 20130
   always_comb
   begin
      meas_d = (64'(cur_raw) * $signed({32'h0, hw_peak_ma})) / $signed(64'(`CUR_SCALE_INCR));
   end

   // saturate rather than wrap if the peak input is set absurdly high
   always_comb
   begin
      if (meas_d > 64'sd2147483647)
         meas_sat = 32'sh7fffffff;
      else if (meas_d < -64'sd2147483648)
         meas_sat = 32'sh80000000;
      else
         meas_sat = meas_d[31:0];
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         meas_q <= '0;
      else
         meas_q <= meas_sat;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         ff_q <= '0;
      else
         ff_q <= ff_sum;
   end

   assign actual_mag = meas_q[31] ? 32'(-meas_q) : meas_q;

   fold_step #(.W(32)) u_step (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .tick(tick_q),
      .actual_mag(actual_mag),
      .continuous(drive_cont_ma),
      .ceiling(fold_ceiling_ma),
      .step(fold_step_ma),
      .limit_q(drive_fold)
   );

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         active_limit_q <= '0;
      else
         active_limit_q <= (drive_fold < limit_p_q) ? drive_fold : limit_p_q;
   end

   // fault latches until reset; drive stays off
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= fold_pkg::st_run;
      else
         case (state_q)
            fold_pkg::st_run:
               if (drive_fold < fault_level_q)
                  state_q <= fold_pkg::st_fault;
            fold_pkg::st_fault:
               state_q <= fold_pkg::st_fault;
            default:
               state_q <= fold_pkg::st_run;
         endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         fault_q <= 1'b0;
      else
         fault_q <= (state_q == fold_pkg::st_fault);
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         drive_enable_q <= 1'b0;
      else
         drive_enable_q <= (state_q == fold_pkg::st_run);
   end

   // select only counts for motor kind 4
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         comm_angle_q <= '0;
      else if (motor_kind_q == `MOTOR_KIND_SELECTABLE && comm_sel_q == `COMM_SEL_SECONDARY)
         comm_angle_q <= secondary_angle;
      else
         comm_angle_q <= primary_angle;
   end

   // readback offsets have no write path
   // select values outside 0..1 refused, still acked
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         comm_sel_q <= `COMM_SEL_RESET;
      else if (reg_wr && reg_addr == `OFS_COMM_SEL && reg_wdata[7:0] <= `COMM_SEL_SECONDARY)
         comm_sel_q <= reg_wdata[7:0];
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         motor_kind_q <= '0;
      else if (reg_wr && reg_addr == `OFS_MOTOR_KIND)
         motor_kind_q <= reg_wdata[7:0];
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         fault_level_q <= '0;
      else if (reg_wr && reg_addr == `OFS_FOLD_FAULT)
         fault_level_q <= reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         limit_p_q <= `FOLD_LIMIT_MAX;
      else if (reg_wr && reg_addr == `OFS_LIMIT_P)
         limit_p_q <= reg_wdata;
   end

   // status flags registered so the read mux stays shallow
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fold_active_q <= 1'b0;
         sel_secondary_q <= 1'b0;
      end
      else
      begin
         fold_active_q <= (drive_fold < limit_p_q);
         sel_secondary_q <= (motor_kind_q == `MOTOR_KIND_SELECTABLE
            && comm_sel_q == `COMM_SEL_SECONDARY);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = '0;
      case (reg_addr)
         `OFS_MEAS_CUR:
            rdata_d = meas_q;
         `OFS_TOTAL_FF:
            rdata_d = ff_q;
         `OFS_DRV_FOLD:
            rdata_d = drive_fold;
         `OFS_COMM_SEL:
            rdata_d = {24'h0, comm_sel_q};
         `OFS_MOTOR_KIND:
            rdata_d = {24'h0, motor_kind_q};
         `OFS_FOLD_FAULT:
            rdata_d = fault_level_q;
         `OFS_LIMIT_P:
            rdata_d = limit_p_q;
         `OFS_STATUS:
            rdata_d = {29'h0, sel_secondary_q, fold_active_q, fault_q};
         default:
            rdata_d = '0;
      endcase
   end

   // read port: data one cycle after strobe, held until the next read
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= '0;
         reg_ack <= 1'b0;
      end
      else
      begin
         reg_ack <= reg_rd | reg_wr;
         if (reg_rd)
            reg_rdata <= rdata_d;
      end
   end
endmodule

/* test/fold_assertions.sv */
// port checker for the foldback monitor
// bound to the top module from the testbench
`timescale 1ns/1ns
`include "fold_cfg.svh"
module fold_assertions (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic [31:0] primary_angle,
   input wire logic [31:0] secondary_angle,
   input wire logic [31:0] active_limit_q,
   input wire logic [31:0] comm_angle_q,
   input wire logic fault_q,
   input wire logic drive_enable_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_fault_disables: assert property ($past(arst_n) |-> drive_enable_q == !fault_q)
      else $error("enable and fault disagree");
   a_fault_sticky: assert property (fault_q |=> fault_q)
      else $error("fault cleared without reset");
   a_write_acked: assert property (reg_wr |=> reg_ack)
      else $error("write not acknowledged");
   a_read_acked: assert property (reg_rd |=> reg_ack)
      else $error("read not acknowledged");
   a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_limit_range: assert property (active_limit_q <= `FOLD_LIMIT_MAX)
      else $error("active limit above range");
   a_limit_lower: assert property (reg_wr && reg_addr == `OFS_LIMIT_P |->
      ##2 active_limit_q <= $past(reg_wdata, 2)) else $error("active limit above limit");
   a_angle_source: assert property ($past(arst_n) |-> comm_angle_q == $past(primary_angle)
      || comm_angle_q == $past(secondary_angle)) else $error("angle from no source");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h000 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   cover property ($rose(fault_q));
   cover property (comm_angle_q == secondary_angle && primary_angle != secondary_angle);
   cover property (reg_wr && reg_addr == `OFS_DRV_FOLD);
endmodule

/* test/motor_model.sv */
// power stage and feedback stand-in: current counts, feedforward, two angles
// load is the de-rotated count chosen by the testbench
`timescale 1ns/1ns
module motor_model (
   input wire logic signed [15:0] load,
   output logic signed [15:0] cur_raw,
   output logic signed [31:0] ff_sum,
   output logic [31:0] primary_angle,
   output logic [31:0] secondary_angle
);
   assign cur_raw = load;
   // opposite sign to load so a sign slip shows
   assign ff_sum = -{{16{load[15]}}, load};
   assign primary_angle = 32'h0000_1111;
   assign secondary_angle = 32'h0000_2222;
endmodule

/* test/tb_current_loop_foldback_monitor.sv */
// testbench for the foldback monitor through its parameter port
// needs the design, motor_model and fold_assertions
`timescale 1ns/1ns
`include "fold_cfg.svh"
module tb_current_loop_foldback_monitor;
   logic ref_clk, arst_n, reg_wr, reg_rd, reg_ack, fault_q, drive_enable_q;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, hw_peak_ma, primary_angle, secondary_angle;
   logic [31:0] active_limit_q, comm_angle_q;
   logic signed [15:0] load, cur_raw;
   logic signed [31:0] ff_sum;
   fold_pkg::reg_word_t rv, f1;
   int n_mismatch = 0;
   int num_checks = 0;
   foldback_monitor #(.STEP_DIV(4), .ADC_W(16)) i_dut (.ref_clk, .arst_n, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .cur_raw, .hw_peak_ma, .ff_sum,
      .drive_cont_ma(32'h384), .fold_ceiling_ma(`FOLD_LIMIT_MAX), .fold_step_ma(32'h1000_0000),
      .primary_angle, .secondary_angle, .active_limit_q, .comm_angle_q, .fault_q, .drive_enable_q);
   motor_model i_motor (.load, .cur_raw, .ff_sum, .primary_angle, .secondary_angle);
   task automatic chk(input fold_pkg::reg_word_t got, input fold_pkg::reg_word_t exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [11:0] a, input fold_pkg::reg_word_t d);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      for (int i = 0; i < 4 && reg_ack !== 1'b1; i++)
         @(negedge ref_clk);
      rv = reg_rdata;
      // registered outputs settle one edge later
      @(negedge ref_clk);
   endtask
   task automatic rdc(input logic [11:0] a, input fold_pkg::reg_word_t e);
      acc(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic rst();
      arst_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      arst_n = 1'b1;
      @(negedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      hw_peak_ma = 32'h2328;
      load = 16'hf823;
      rst();
      chk(32'(drive_enable_q), 32'h1);
      rdc(`OFS_COMM_SEL, 32'h0);
      rdc(`OFS_DRV_FOLD, `FOLD_LIMIT_MAX);
      rdc(`OFS_MEAS_CUR, 32'hfffffc7c);
      rdc(`OFS_TOTAL_FF, 32'h7dd);
      rdc(12'h000, 32'h0);
      hw_peak_ma = 32'h1194;
      @(negedge ref_clk);
      rdc(`OFS_MEAS_CUR, 32'hfffffe3e);
      hw_peak_ma = 32'h2328;
      acc(1'b1, `OFS_MEAS_CUR, 32'h0);
      rdc(`OFS_MEAS_CUR, 32'hfffffc7c);
      acc(1'b1, `OFS_TOTAL_FF, 32'h0);
      rdc(`OFS_TOTAL_FF, 32'h7dd);
      acc(1'b1, `OFS_DRV_FOLD, 32'h0);
      rdc(`OFS_DRV_FOLD, `FOLD_LIMIT_MAX);
      acc(1'b1, `OFS_COMM_SEL, 32'h1);
      chk(comm_angle_q, primary_angle);
      acc(1'b1, `OFS_MOTOR_KIND, 32'h4);
      chk(comm_angle_q, secondary_angle);
      acc(1'b1, `OFS_COMM_SEL, 32'h2);
      rdc(`OFS_COMM_SEL, 32'h1);
      acc(1'b1, `OFS_COMM_SEL, 32'h0);
      chk(comm_angle_q, primary_angle);
      acc(1'b1, `OFS_LIMIT_P, 32'h1388);
      chk(active_limit_q, 32'h1388);
      acc(1'b1, `OFS_LIMIT_P, `FOLD_LIMIT_MAX);
      // overload, then equal to continuous so the limit holds still
      load = 16'h4ea2;
      repeat (20) @(negedge ref_clk);
      load = 16'h07dd;
      repeat (4) @(negedge ref_clk);
      acc(1'b0, `OFS_DRV_FOLD, 32'h0);
      f1 = rv;
      chk(32'(f1 < `FOLD_LIMIT_MAX), 32'h1);
      chk(active_limit_q, f1);
      load = 16'h0000;
      repeat (8) @(negedge ref_clk);
      load = 16'h07dd;
      repeat (4) @(negedge ref_clk);
      acc(1'b0, `OFS_DRV_FOLD, 32'h0);
      chk(32'(rv > f1), 32'h1);
      acc(1'b1, `OFS_FOLD_FAULT, rv + 32'h1);
      // level lands, state moves, then the output flop
      @(negedge ref_clk);
      chk(32'(fault_q), 32'h1);
      rdc(`OFS_STATUS, 32'h3);
      chk(32'(drive_enable_q), 32'h0);
      rst();
      chk(32'(fault_q), 32'h0);
      end_of_test();
   end
   initial
   begin
      // traffic needs a few hundred cycles at most
      #20000;
      n_mismatch++;
      end_of_test();
   end
endmodule
bind foldback_monitor fold_assertions i_chk (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_ack, .primary_angle, .secondary_angle, .active_limit_q,
   .comm_angle_q, .fault_q, .drive_enable_q);
